//--- hw/dcct_counter.sv
`timescale 1ns/1ps
module dcct_counter (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Control
  input  wire logic        i_tick,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wr_val,
  input  wire logic        i_use_reload,
  input  wire logic [15:0] i_reload,
  input  wire logic        i_preset,
  // Status
  output logic      [15:0] o_count,
  output logic             o_underflow
);

  logic [15:0] count_reg;

  // Underflow is a tick while at zero
  assign o_underflow = i_tick && (count_reg == 16'h0000);
  assign o_count     = count_reg;

  // Write wins, then preset, then counting
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= dcct_pkg::RST_CNT;
    end else if (i_wr) begin
      count_reg <= i_wr_val;
    end else if (i_preset) begin
      count_reg <= dcct_pkg::PRESET_CNT;
    end else if (o_underflow && i_use_reload) begin
      count_reg <= i_reload;
    end else if (i_tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

endmodule : dcct_counter

//--- hw/dcct_pkg.sv
package dcct_pkg;

  // Bus and data widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int PSC_W  = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_CLKSEL   = 8'h04;
  localparam logic [7:0] OFS_CNT_ONE  = 8'h08;
  localparam logic [7:0] OFS_CNT_TWO  = 8'h0C;
  localparam logic [7:0] OFS_RLD_A    = 8'h10;
  localparam logic [7:0] OFS_RLD_B    = 8'h14;
  localparam logic [7:0] OFS_MODE_CTL = 8'h18;
  localparam logic [7:0] OFS_IRQ_CTL  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;

  // Clock select fields
  localparam int CSEL_ONE_LSB = 0;
  localparam int CSEL_TWO_LSB = 3;
  localparam int CSEL_W       = 3;

  // Mode control fields
  localparam int MODE_LSB     = 0;
  localparam int EDGE_A_BIT   = 2;
  localparam int EDGE_B_BIT   = 3;
  localparam int FEN_A_BIT    = 4;
  localparam int PRE_B_BIT    = 5;
  localparam int START_A_BIT  = 6;
  localparam int MODE_CTL_W   = 7;

  // Interrupt control fields: enables low, pending flags above
  localparam int IRQ_SRC_N    = 4;
  localparam int PEND_LSB     = 4;
  localparam int SRC_A        = 0;
  localparam int SRC_B        = 1;
  localparam int SRC_C        = 2;
  localparam int SRC_D        = 3;

  // Reset and preset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_CNT    = 16'h0000;
  localparam logic [15:0] PRESET_CNT = 16'hFFFF;

  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PIN_MIN_PULSE_NS = 100;
  localparam int PIN_MIN_PULSE_CYC =
    (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_PWM        = 2'h0,
    MODE_DUAL_CAP   = 2'h1,
    MODE_DUAL_TMR   = 2'h2,
    MODE_SINGLE_CAP = 2'h3
  } dcct_mode_e;

  // Counter clock sources
  typedef enum logic [2:0] {
    CS_STOP   = 3'h0,
    CS_PRESC  = 3'h1,
    CS_EVENT  = 3'h2,
    CS_ACCUM  = 3'h3,
    CS_SLOW   = 3'h4
  } dcct_clksel_e;

endpackage : dcct_pkg

//--- hw/dcct_timer.sv
// Operation
// - Dual capture: counter one counts; pin edges copy it to A or B.
// - Each capture pin has its own rising or falling edge select.
// - Preset enabled: capture stores count, then counter loads FFFF.
// - Dual capture sets flags A, B and C, each with own enable.
// - Dual capture: counter two plain timer, underflow sets flag D.
// - Capture modes: event or accumulate clock stops the counter.
// - Dual timer: counter one reloads from register A on underflow.
// - Timer modes: pin A toggles on counter one underflow; start level from software.
// - Timer modes: pin A rising toggle sets flag C, gated by enable A.
// - Dual timer: counter two reloads from B, underflow sets flag D.
// - Dual timer: pin B event, accumulate or prescaled clock usable.
// - Single capture: counter one behaves as in dual timer mode.
// - Single capture: pin B copies counter two, optional FFFF preset.
// - Single capture sets flag B on capture, D on counter two underflow.
// - Sources A, B, C form interrupt one; D alone forms interrupt two.
// - First unit delivers interrupts one and two on lines 13 and 12.
// - Second unit delivers interrupts one and two on lines 11 and 10.
// - Mode 00 PWM, 01 dual capture, 10 dual timer, 11 single capture.
// - Clock select: stop, prescaled, pin B event, accumulate, slow.
// - Prescaled clock is system clock divided by prescale value plus one.
`timescale 1ns/1ps
module dcct_timer #(
  parameter int UNIT_NUM = 1
) (
  // Clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESET_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Timer pins and slow clock
  input  wire logic        I_TIMER_PIN_A_IN,
  output logic             O_TIMER_PIN_A_OUT,
  output logic             O_TIMER_PIN_A_OE,
  input  wire logic        I_TIMER_PIN_B,
  input  wire logic        I_SLOW_CLK,
  // System interrupt lines
  output logic             O_UNIT1_TIMER_IRQ_ONE,
  output logic             O_UNIT1_TIMER_IRQ_TWO,
  output logic             O_UNIT2_TIMER_IRQ_ONE,
  output logic             O_UNIT2_TIMER_IRQ_TWO
);

  logic [4:0]  prescale_value_reg;
  logic [4:0]  psc_cnt_reg;
  logic [5:0]  clk_sel_reg;
  logic [6:0]  mode_ctl_reg;
  logic [3:0]  irq_en_reg;
  logic [3:0]  pend_reg;
  logic [15:0] reload_capture_a_reg;
  logic [15:0] reload_capture_b_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  samp_reg;
  logic        pin_a_reg;
  logic        pin_a_oe_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        irq_one_reg;
  logic        irq_two_reg;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_en;
  logic        presc_tick;
  logic        slow_tick;
  logic        a_evt;
  logic        b_evt;
  logic        tick_one;
  logic        tick_two;
  logic        uf_one;
  logic        uf_two;
  logic        toggle_en;
  logic        is_dual_cap;
  logic        is_single_cap;
  logic        cap_mode;
  logic [3:0]  set_ev;
  logic [15:0] counter_one;
  logic [15:0] counter_two;
  dcct_pkg::dcct_mode_e mode_selector;
  dcct_pkg::dcct_clksel_e counter_one_clock_select;
  dcct_pkg::dcct_clksel_e counter_two_clock_select;

  // Control field decode
  assign mode_selector = dcct_pkg::dcct_mode_e'(mode_ctl_reg[1:0]);
  assign counter_one_clock_select =
    dcct_pkg::dcct_clksel_e'(clk_sel_reg[2:0]);
  assign counter_two_clock_select =
    dcct_pkg::dcct_clksel_e'(clk_sel_reg[5:3]);
  assign is_dual_cap   = (mode_selector == dcct_pkg::MODE_DUAL_CAP);
  assign is_single_cap = (mode_selector == dcct_pkg::MODE_SINGLE_CAP);
  assign cap_mode      = is_dual_cap || is_single_cap;
  assign wr_en = I_PSEL && I_PENABLE && pready_reg && I_PWRITE;

  // Two-stage synchronisers plus one sample for edge detection
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      samp_reg  <= 3'h0;
    end else begin
      sync1_reg <= {I_TIMER_PIN_A_IN, I_TIMER_PIN_B, I_SLOW_CLK};
      sync2_reg <= sync1_reg;
      samp_reg  <= sync2_reg;
    end
  end

  // Edge events with per-pin polarity
  assign a_evt = mode_ctl_reg[dcct_pkg::EDGE_A_BIT] ?
                 (samp_reg[2] && !sync2_reg[2]) :
                 (!samp_reg[2] && sync2_reg[2]);
  assign b_evt = mode_ctl_reg[dcct_pkg::EDGE_B_BIT] ?
                 (samp_reg[1] && !sync2_reg[1]) :
                 (!samp_reg[1] && sync2_reg[1]);
  assign slow_tick = sync2_reg[0] && !samp_reg[0];

  // Prescaler: one tick every prescale_value+1 cycles
  assign presc_tick = (psc_cnt_reg == 5'h00);
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      psc_cnt_reg <= 5'h00;
    end else if (presc_tick) begin
      psc_cnt_reg <= prescale_value_reg;
    end else begin
      psc_cnt_reg <= psc_cnt_reg - 5'h01;
    end
  end

  // Clock source selection for one counter
  function automatic logic sel_tick(input dcct_pkg::dcct_clksel_e sel);
    logic t;
    t = 1'b0;
    case (sel)
      dcct_pkg::CS_STOP:  t = 1'b0;
      dcct_pkg::CS_PRESC: t = presc_tick;
      dcct_pkg::CS_EVENT: t = b_evt && !cap_mode;
      dcct_pkg::CS_ACCUM: t = presc_tick && !cap_mode &&
        (sync2_reg[1] ^ mode_ctl_reg[dcct_pkg::EDGE_B_BIT]);
      dcct_pkg::CS_SLOW:  t = slow_tick;
      default:            t = 1'b0;
    endcase
    return t;
  endfunction

  // Counter one idles in the PWM mode, which this block omits
  // A process, so that the signals read inside the function wake it
  always_comb begin
    tick_one = sel_tick(counter_one_clock_select) &&
               (mode_selector != dcct_pkg::MODE_PWM);
    tick_two = sel_tick(counter_two_clock_select);
  end

  dcct_counter u_counter_one (
    .i_clk        (I_SYS_CLK),
    .i_rst_n      (I_RESET_N),
    .i_tick       (tick_one),
    .i_wr         (wr_en && I_PADDR == dcct_pkg::OFS_CNT_ONE),
    .i_wr_val     (I_PWDATA[15:0]),
    .i_use_reload (!is_dual_cap),
    .i_reload     (reload_capture_a_reg),
    .i_preset     (is_dual_cap &&
                   ((a_evt && mode_ctl_reg[dcct_pkg::FEN_A_BIT]) ||
                    (b_evt && mode_ctl_reg[dcct_pkg::PRE_B_BIT]))),
    .o_count      (counter_one),
    .o_underflow  (uf_one)
  );

  dcct_counter u_counter_two (
    .i_clk        (I_SYS_CLK),
    .i_rst_n      (I_RESET_N),
    .i_tick       (tick_two),
    .i_wr         (wr_en && I_PADDR == dcct_pkg::OFS_CNT_TWO),
    .i_wr_val     (I_PWDATA[15:0]),
    .i_use_reload (mode_selector == dcct_pkg::MODE_DUAL_TMR),
    .i_reload     (reload_capture_b_reg),
    .i_preset     (is_single_cap && b_evt &&
                   mode_ctl_reg[dcct_pkg::PRE_B_BIT]),
    .o_count      (counter_two),
    .o_underflow  (uf_two)
  );

  // Reload/capture registers; a capture beats a same-cycle write
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      reload_capture_a_reg <= dcct_pkg::RST_CNT;
      reload_capture_b_reg <= dcct_pkg::RST_CNT;
    end else begin
      if (is_dual_cap && a_evt) begin
        reload_capture_a_reg <= counter_one;
      end else if (wr_en && I_PADDR == dcct_pkg::OFS_RLD_A) begin
        reload_capture_a_reg <= I_PWDATA[15:0];
      end
      if (cap_mode && b_evt) begin
        reload_capture_b_reg <= is_dual_cap ? counter_one
                                            : counter_two;
      end else if (wr_en && I_PADDR == dcct_pkg::OFS_RLD_B) begin
        reload_capture_b_reg <= I_PWDATA[15:0];
      end
    end
  end

  // Pin A square wave; a mode write sets the starting level
  assign toggle_en = mode_ctl_reg[dcct_pkg::FEN_A_BIT] && !is_dual_cap;
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pin_a_reg    <= 1'b0;
      pin_a_oe_reg <= 1'b0;
    end else begin
      pin_a_oe_reg <= toggle_en;
      if (wr_en && I_PADDR == dcct_pkg::OFS_MODE_CTL) begin
        pin_a_reg <= I_PWDATA[dcct_pkg::START_A_BIT];
      end else if (toggle_en && uf_one) begin
        pin_a_reg <= !pin_a_reg;
      end
    end
  end

  // Pending flag sources per mode
  assign set_ev[dcct_pkg::SRC_A] = is_dual_cap && a_evt;
  assign set_ev[dcct_pkg::SRC_B] = cap_mode && b_evt;
  assign set_ev[dcct_pkg::SRC_C] = (is_dual_cap && uf_one) ||
    (!is_dual_cap && toggle_en && uf_one && !pin_a_reg);
  assign set_ev[dcct_pkg::SRC_D] = uf_two;

  // Flags are sticky; a set beats a same-cycle clear
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pend_reg <= 4'h0;
    end else if (wr_en && I_PADDR == dcct_pkg::OFS_IRQ_CLR) begin
      pend_reg <= (pend_reg & ~I_PWDATA[3:0]) | set_ev;
    end else begin
      pend_reg <= pend_reg | set_ev;
    end
  end

  // Interrupt lines; C is gated by enable A outside dual capture
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      irq_one_reg <= 1'b0;
      irq_two_reg <= 1'b0;
    end else begin
      irq_one_reg <= (pend_reg[0] && irq_en_reg[0]) ||
                     (pend_reg[1] && irq_en_reg[1]) ||
                     (pend_reg[2] &&
                      (is_dual_cap ? irq_en_reg[2]
                                   : irq_en_reg[0]));
      irq_two_reg <= pend_reg[3] && irq_en_reg[3];
    end
  end

  // Software control registers
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prescale_value_reg <= 5'h00;
      clk_sel_reg        <= 6'h00;
      mode_ctl_reg       <= 7'h00;
      irq_en_reg         <= 4'h0;
    end else if (wr_en) begin
      case (I_PADDR)
        dcct_pkg::OFS_PRESCALE: prescale_value_reg <= I_PWDATA[4:0];
        dcct_pkg::OFS_CLKSEL:   clk_sel_reg        <= I_PWDATA[5:0];
        dcct_pkg::OFS_MODE_CTL: mode_ctl_reg       <= I_PWDATA[6:0];
        dcct_pkg::OFS_IRQ_CTL:  irq_en_reg         <= I_PWDATA[3:0];
        default: ;
      endcase
    end
  end

  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (I_PADDR)
      dcct_pkg::OFS_PRESCALE: rd_data = {27'h0, prescale_value_reg};
      dcct_pkg::OFS_CLKSEL:   rd_data = {26'h0, clk_sel_reg};
      dcct_pkg::OFS_CNT_ONE:  rd_data = {16'h0, counter_one};
      dcct_pkg::OFS_CNT_TWO:  rd_data = {16'h0, counter_two};
      dcct_pkg::OFS_RLD_A:    rd_data = {16'h0, reload_capture_a_reg};
      dcct_pkg::OFS_RLD_B:    rd_data = {16'h0, reload_capture_b_reg};
      dcct_pkg::OFS_MODE_CTL: rd_data = {25'h0, mode_ctl_reg};
      dcct_pkg::OFS_IRQ_CTL:  rd_data = {24'h0, pend_reg, irq_en_reg};
      dcct_pkg::OFS_IRQ_CLR:  rd_data = 32'h0000_0000;
      default:                rd_ok   = 1'b0;
    endcase
  end

  // APB answer registered in the setup cycle, ready in access
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= I_PSEL && !I_PENABLE;
      if (I_PSEL && !I_PENABLE) begin
        prdata_reg  <= I_PWRITE ? 32'h0000_0000 : rd_data;
        pslverr_reg <= !rd_ok;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Output pins
  assign O_PRDATA          = prdata_reg;
  assign O_PREADY          = pready_reg;
  assign O_PSLVERR         = pslverr_reg;
  assign O_TIMER_PIN_A_OUT = pin_a_reg;
  assign O_TIMER_PIN_A_OE  = pin_a_oe_reg;
  assign O_UNIT1_TIMER_IRQ_ONE = (UNIT_NUM == 1) && irq_one_reg;
  assign O_UNIT1_TIMER_IRQ_TWO = (UNIT_NUM == 1) && irq_two_reg;
  assign O_UNIT2_TIMER_IRQ_ONE = (UNIT_NUM == 2) && irq_one_reg;
  assign O_UNIT2_TIMER_IRQ_TWO = (UNIT_NUM == 2) && irq_two_reg;

  // Checks
  property p_cap_a;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    is_dual_cap && a_evt |=> reload_capture_a_reg == $past(counter_one);
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("capture A wrong");

  property p_preset;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    is_dual_cap && b_evt && mode_ctl_reg[dcct_pkg::PRE_B_BIT] && !wr_en
      |=> counter_one == 16'hFFFF;
  endproperty
  a_preset: assert property (p_preset) else $error("no preset");

  property p_flag_sticky;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    set_ev[dcct_pkg::SRC_A] ||
      (pend_reg[dcct_pkg::SRC_A] &&
       !(wr_en && I_PADDR == dcct_pkg::OFS_IRQ_CLR))
      |=> pend_reg[dcct_pkg::SRC_A];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag A lost");

  property p_stop;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    cap_mode && counter_two_clock_select == dcct_pkg::CS_EVENT
      |-> !tick_two && !uf_two;
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran");

  property p_reload;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    mode_selector == dcct_pkg::MODE_DUAL_TMR && uf_one && !wr_en
      |=> counter_one == $past(reload_capture_a_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload A");

  property p_toggle;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    toggle_en && uf_one && !wr_en |=> O_TIMER_PIN_A_OUT != $past(pin_a_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin A stuck");

  property p_irq_two;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    uf_two && irq_en_reg[3] && !wr_en && UNIT_NUM == 1
      |=> ##1 O_UNIT1_TIMER_IRQ_TWO;
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("irq two late");

  property p_presc;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    presc_tick && prescale_value_reg == 5'h01 && !wr_en
      |=> !presc_tick ##1 presc_tick;
  endproperty
  a_presc: assert property (p_presc) else $error("prescale wrong");

  property p_cap_b4;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    is_single_cap && b_evt |=> reload_capture_b_reg == $past(counter_two);
  endproperty
  a_cap_b4: assert property (p_cap_b4) else $error("capture B wrong");

  property p_one_evt;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    a_evt && !wr_en |=> !a_evt;
  endproperty
  a_one_evt: assert property (p_one_evt) else $error("double event");

endmodule : dcct_timer

//--- sim/dcct_pin_model.sv
`timescale 1ns/1ps
module dcct_pin_model (
  // Clock
  input  wire logic i_clk,
  // Levels asked for by the bench
  input  wire logic i_lvl_a,
  input  wire logic i_lvl_b,
  // Pin A drive from the timer
  input  wire logic i_drv_a,
  input  wire logic i_oe_a,
  // Pin levels seen by the timer
  output logic      o_pin_a,
  output logic      o_pin_b
);
  logic a_reg = 1'b0;
  logic b_reg = 1'b0;

  // Levels move only at edges, so every pulse lasts whole clocks
  always @(posedge i_clk) begin
    a_reg <= i_lvl_a;
    b_reg <= i_lvl_b;
  end

  // Pin A wire follows the timer while it drives
  assign o_pin_a = i_oe_a ? i_drv_a : a_reg;
  assign o_pin_b = b_reg;
endmodule : dcct_pin_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        slow = 1'b0;
  logic [2:0]  sdiv = 3'h0;
  logic        lvl_a = 1'b0;
  logic        lvl_b = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, pa_out, pa_oe, pa_in, pb;
  logic        irq1, irq2, irq3, irq4;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  logic [31:0] seed = 32'h00008B5E;
  int          failures = 0;
  int          n_tests = 0;

  // System clock and a slow clock of sixteen cycles
  always #50 clk = ~clk;
  always @(posedge clk) begin
    sdiv <= sdiv + 3'h1;
    if (sdiv == 3'h7) slow <= ~slow;
  end

  dcct_timer #(.UNIT_NUM(1)) i_dcct_timer (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TIMER_PIN_A_IN(pa_in),
    .O_TIMER_PIN_A_OUT(pa_out), .O_TIMER_PIN_A_OE(pa_oe),
    .I_TIMER_PIN_B(pb), .I_SLOW_CLK(slow), .O_UNIT1_TIMER_IRQ_ONE(irq1),
    .O_UNIT1_TIMER_IRQ_TWO(irq2), .O_UNIT2_TIMER_IRQ_ONE(irq3),
    .O_UNIT2_TIMER_IRQ_TWO(irq4));

  dcct_pin_model i_dcct_pin_model (
    .i_clk(clk), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b), .i_drv_a(pa_out),
    .i_oe_a(pa_oe), .o_pin_a(pa_in), .o_pin_b(pb));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic results();
    $display("Tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // One APB transfer; the note goes on the queue before the request
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] e,
                     output logic [31:0] r);
    int k;
    exp_q.push_back(e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    // One idle edge, so the next call never re-drives psel in this step
    @(posedge clk);
    if (k >= 50) begin
      failures++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, {2'b00, d}, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, {2'b10, e}, r);
  endtask : rd

  task automatic rdq(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h00000000, 34'h000000000, r);
  endtask : rdq

  // Drive a pin level, then let sync, capture and flag settle
  task automatic pin(input logic b, input logic v);
    if (b) lvl_b <= v;
    else lvl_a <= v;
    repeat (8) @(posedge clk);
  endtask : pin

  // Cycles between two successive toggles of pin A
  task automatic gap(output int n);
    logic l;
    for (int j = 0; j < 2; j++) begin
      l = pa_out;
      n = 0;
      while (pa_out === l && n < 200) begin
        @(posedge clk);
        n++;
      end
    end
    if (n >= 200) begin
      failures++;
      results();
    end
  endtask : gap

  // Every completed transfer is matched against the oldest note
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      mon_e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, mon_e[32]}, "slverr");
      if (mon_e[33]) chk(prdata, mon_e[31:0], "rdata");
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] v;
    logic [31:0] c0;
    logic [15:0] d;
    int          n;
    int          ex[5];
    ex = '{0, 16, 0, 0, 4};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, an unmapped and a misaligned access
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h00000000);
    apb(1'b0, 8'h24, 32'h00000000, 34'h100000000, r);
    apb(1'b1, 8'h02, 32'h00000001, 34'h100000000, r);
    $display("test reset done");
    // Dual capture with stopped counters and preset on both pins
    seed = xs(seed);
    v = {16'h0000, seed[15:0]};
    wr(dcct_pkg::OFS_CLKSEL, 32'h0000001A);
    wr(dcct_pkg::OFS_CNT_ONE, v);
    wr(dcct_pkg::OFS_CNT_TWO, v);
    wr(dcct_pkg::OFS_MODE_CTL, 32'h00000039);
    pin(1'b0, 1'b1);
    rd(dcct_pkg::OFS_RLD_A, v);
    rd(dcct_pkg::OFS_CNT_ONE, 32'h0000FFFF);
    pin(1'b1, 1'b1);
    rd(dcct_pkg::OFS_RLD_B, 32'h00000000);
    pin(1'b1, 1'b0);
    rd(dcct_pkg::OFS_RLD_B, 32'h0000FFFF);
    rd(dcct_pkg::OFS_CNT_TWO, v);
    rd(dcct_pkg::OFS_IRQ_CTL, 32'h00000030);
    chk({31'h0, irq1}, 32'h0, "irq gated");
    wr(dcct_pkg::OFS_IRQ_CTL, 32'h00000001);
    repeat (3) @(posedge clk);
    chk({31'h0, irq1}, 32'h1, "irq one");
    wr(dcct_pkg::OFS_IRQ_CLR, 32'h000000FF);
    rd(dcct_pkg::OFS_IRQ_CTL, 32'h00000001);
    $display("test dual capture done");
    // Counter one underflow and counter two clock sources
    wr(dcct_pkg::OFS_CNT_ONE, 32'h00000003);
    wr(dcct_pkg::OFS_CNT_TWO, 32'h00008000);
    wr(dcct_pkg::OFS_CLKSEL, 32'h00000001);
    repeat (10) @(posedge clk);
    rdq(dcct_pkg::OFS_IRQ_CTL, r);
    chk(r & 32'h00000070, 32'h00000040, "flag c");
    wr(dcct_pkg::OFS_PRESCALE, 32'h00000003);
    for (int s = 0; s < 5; s++) begin
      wr(dcct_pkg::OFS_CLKSEL, 32'(s << 3));
      rdq(dcct_pkg::OFS_CNT_TWO, c0);
      repeat (62) @(posedge clk);
      rdq(dcct_pkg::OFS_CNT_TWO, r);
      d = c0[15:0] - r[15:0];
      n = (ex[s] == 0) ? int'(d == 16'h0) : int'(16'(d + 1 - ex[s]) <= 2);
      chk(32'(n), 32'h1, "count rate");
    end
    wr(dcct_pkg::OFS_MODE_CTL, 32'h00000002);
    wr(dcct_pkg::OFS_CLKSEL, 32'h00000010);
    rdq(dcct_pkg::OFS_CNT_TWO, c0);
    for (int p = 0; p < 3; p++) begin
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
    end
    rdq(dcct_pkg::OFS_CNT_TWO, r);
    chk(32'(c0[15:0] - r[15:0]), 32'h3, "event count");
    $display("test clock sources done");
    // Dual timer: reloads, square wave, flags C and D
    wr(dcct_pkg::OFS_PRESCALE, 32'h00000001);
    wr(dcct_pkg::OFS_RLD_A, 32'h00000004);
    wr(dcct_pkg::OFS_CNT_ONE, 32'h00000004);
    wr(dcct_pkg::OFS_RLD_B, 32'h00000002);
    wr(dcct_pkg::OFS_CNT_TWO, 32'h00000002);
    wr(dcct_pkg::OFS_IRQ_CTL, 32'h0000000D);
    wr(dcct_pkg::OFS_MODE_CTL, 32'h00000052);
    wr(dcct_pkg::OFS_IRQ_CLR, 32'h000000FF);
    chk({30'h0, pa_out, pa_oe}, 32'h3, "start level");
    wr(dcct_pkg::OFS_CLKSEL, 32'h00000009);
    gap(n);
    chk(32'(n), 32'd10, "toggle period");
    rdq(dcct_pkg::OFS_IRQ_CTL, r);
    chk(r & 32'h000000F0, 32'h000000C0, "flags c d");
    chk({30'h0, irq1, irq2}, 32'h3, "irq lines");
    rdq(dcct_pkg::OFS_CNT_TWO, r);
    chk(32'(r <= 32'h2), 32'h1, "reload b");
    $display("test dual timer done");
    // Single capture on pin B with preset, counter one still reloading
    wr(dcct_pkg::OFS_MODE_CTL, 32'h00000033);
    wr(dcct_pkg::OFS_IRQ_CTL, 32'h00000002);
    wr(dcct_pkg::OFS_IRQ_CLR, 32'h000000FF);
    pin(1'b1, 1'b1);
    rdq(dcct_pkg::OFS_CNT_TWO, r);
    chk(32'(r >= 32'hFFF0), 32'h1, "preset two");
    rdq(dcct_pkg::OFS_IRQ_CTL, r);
    chk(r & 32'h00000020, 32'h00000020, "flag b");
    chk({31'h0, irq1}, 32'h1, "irq one b");
    gap(n);
    chk(32'(n), 32'd10, "toggle period");
    chk({30'h0, irq3, irq4}, 32'h0, "other unit");
    $display("test single capture done");
    results();
  end
endmodule : tb_top
